// file: rtl/pmc_params.svh
// constants for the memory pll clock controller: offsets, fields, resets, counts
// assumes byte addresses on a 12-bit window of a 32-bit wishbone slave
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// register byte offsets
`define PMC_OFS_CTL 12'h100
`define PMC_OFS_MULT 12'h110
`define PMC_OFS_VID 12'h118
`define PMC_OFS_PHY 12'h11C
`define PMC_OFS_BYP 12'h12C
`define PMC_OFS_CMD 12'h138
`define PMC_OFS_STAT 12'h13C

// pll_control_word fields
`define PMC_CTL_EN 0
`define PMC_CTL_PWRDN 1
`define PMC_CTL_RST 3
`define PMC_CTL_DIS 4
`define PMC_CTL_ENSRC 5
`define PMC_CTL_REFSEL 8
`define PMC_CTL_RESET 32'h0000_00F2
`define PMC_CTL_WMASK 32'h0000_013B

// divider registers: ratio is divide factor minus one, plus an enable bit
`define PMC_RATIO_W 5
`define PMC_DIV_EN 15
`define PMC_VID_RESET 32'h0000_8009
`define PMC_PHY_RESET 32'h0000_8001
`define PMC_BYP_RESET 32'h0000_8001
`define PMC_DIV_WMASK 32'h0000_801F

// multiplier_setting
`define PMC_MULT_W 5
`define PMC_MULT_RESET 32'h0000_0010

// command and status bits
`define PMC_CMD_GO 0
`define PMC_STAT_GO 0
`define PMC_STAT_LOCK 1
`define PMC_STAT_SELPLL 2

// reference ticks spent before the source select flips
`define PMC_SWITCH_TICKS 2'h2

`endif

// file: rtl/pmc_pkg.sv
// types shared by the memory pll clock controller files
// assumes pmc_params.svh supplies all numeric constants
package pmc_pkg;
    typedef logic [4:0] pmc_ratio_t;     // divide factor minus one
    typedef logic [31:0] pmc_word_t;     // one register word
    typedef enum logic [1:0] {
        PMC_GO_IDLE = 2'b00,  // no divider transition pending
        PMC_GO_ALIGN = 2'b01, // waiting for a source edge to load all dividers
        PMC_GO_SETTLE = 2'b10 // first aligned period running
    } pmc_go_e;
endpackage

// file: rtl/pmc_clkdiv.sv
// one programmable clock divider driven by source tick enables
// assumes tick_i is a one-cycle pulse per source clock edge
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_clkdiv (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic en_i,
    input wire pmc_pkg::pmc_ratio_t ratio_i,
    input wire pmc_pkg::pmc_ratio_t reset_ratio_i,
    output logic clk_o
);
    import pmc_pkg::*;

    pmc_ratio_t cnt_ff, nxt_cnt;     // position within the period
    pmc_ratio_t ratio_ff, nxt_ratio; // ratio in use
    logic clk_ff, nxt_clk;           // divided clock level
    logic [5:0] half;                // ticks spent high

    // count source ticks; a load restarts the period so that all dividers align
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_ratio = ratio_ff;
        nxt_clk = clk_ff;
        half = (6'({1'b0, ratio_ff}) + 6'h01) >> 1;
        if (load_i) begin
            // new ratio adopted on an aligned rising edge; no own tick is needed, so the
            // reference-fed divider still takes its ratio on a load from the pll source
            nxt_ratio = ratio_i;
            nxt_cnt = '0;
            nxt_clk = 1'b1;
        end else if (tick_i) begin
            nxt_cnt = (cnt_ff == ratio_ff) ? '0 : pmc_ratio_t'(cnt_ff + 5'h01);
            // divide by one simply follows every source edge
            nxt_clk = (ratio_ff == '0) ? ~clk_ff : (6'(nxt_cnt) < half);
        end
        if (!en_i) begin
            nxt_clk = 1'b0; // disabled output parks low
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            ratio_ff <= reset_ratio_i;
            clk_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            ratio_ff <= nxt_ratio;
            clk_ff <= nxt_clk;
        end
    end

    assign clk_o = clk_ff;

    // a load on a tick must give a rising edge at once
    load_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (load_i && en_i) |=> (clk_o && cnt_ff == '0 && ratio_ff == $past(ratio_i)))
        else $error("divider did not restart on load");

    // without a source tick, a load or a drop of enable the divided level never moves
    no_tick_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!tick_i && !load_i && en_i && $past(en_i)) |=> $stable(clk_o))
        else $error("divider moved without a source tick");
endmodule

// file: rtl/pmc_srcsel.sv
// glitch-safe choice between the reference and the pll as divider source
// assumes ref and pll edges arrive as one-cycle tick pulses on clk_i
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_srcsel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_tick_i,
    input wire logic pll_tick_i,
    input wire logic want_pll_i,
    input wire logic pll_ok_i,
    output logic sel_pll_o,
    output logic src_tick_o
);
    logic sel_ff, nxt_sel;      // current source, 1 = pll
    logic [1:0] wait_ff, nxt_wait; // reference ticks seen since a change was asked
    logic [2:0] mis_ff;         // helper: reference ticks while a switch is pending

    // the change waits on reference ticks so it completes within four of them
    always_comb begin
        nxt_sel = sel_ff;
        nxt_wait = wait_ff;
        if (want_pll_i == sel_ff) begin
            nxt_wait = '0;
        end else if (ref_tick_i) begin
            if (wait_ff == `PMC_SWITCH_TICKS - 2'h1) begin
                nxt_sel = want_pll_i;
                nxt_wait = '0;
            end else begin
                nxt_wait = wait_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_ff <= 1'b0;
            wait_ff <= '0;
        end else begin
            sel_ff <= nxt_sel;
            wait_ff <= nxt_wait;
        end
    end

    // in bypass only the reference drives the dividers
    assign src_tick_o = sel_ff ? (pll_tick_i & pll_ok_i) : ref_tick_i;
    assign sel_pll_o = sel_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || sel_ff == want_pll_i) begin
            mis_ff <= '0;
        end else if (ref_tick_i) begin
            mis_ff <= mis_ff + 3'h1;
        end
    end

    switch_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mis_ff < 3'h4)
        else $error("bypass switch took four reference cycles");

    bypass_iso_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!sel_pll_o && !ref_tick_i) |-> !src_tick_o)
        else $error("pll edge leaked while in bypass");
endmodule

// file: rtl/pmc_ctrl.sv
// memory pll clock controller: wishbone registers, bypass switch, go sequencer
// assumes ref_tick_i and pll_tick_i are one-cycle pulses synchronous to clk_i
`timescale 1ns/1ps
`include "pmc_params.svh"

// Function
// - exactly two programmable pll-derived output clocks
// - phy divider resets to two, writable
// - video divider programmable for 54 MHz
// - global resets force pll power-down
// - bypass switch completes within four reference cycles
// - pll edges blocked while in bypass
// - mode enable one selects locked pll; the code selects the pll without looking at pll_lock_i
// - go-set starts aligned divider transition
// - go status high while transition pending
// - bypass clocks come from reference input
// - enable source must be zero for mode
// - pll reset bit zero asserts reset
// - output disable bit one asserts disable
module pmc_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic warm_rst_i,
    input wire logic max_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire pmc_pkg::pmc_word_t wb_dat_i,
    output pmc_pkg::pmc_word_t wb_dat_o,
    output logic wb_ack_o,
    input wire logic ref_tick_i,
    input wire logic pll_tick_i,
    input wire logic pll_lock_i,
    output logic pll_reset_o,
    output logic pll_disable_o,
    output logic pll_power_down_o,
    output logic [4:0] multiplier_setting_o,
    output logic ref_source_select_o,
    output logic video_clock_out_o,
    output logic phy_clock_out_o,
    output logic bypass_divided_clock_o,
    output logic bypass_active_o
);
    import pmc_pkg::*;

    logic grst; // any reset source clears the whole controller
    pmc_word_t ctl_ff, nxt_ctl;   // pll_control_word
    pmc_word_t mult_ff, nxt_mult; // multiplier_setting
    pmc_word_t vid_ff, nxt_vid;   // video_divider_reg
    pmc_word_t phy_ff, nxt_phy;   // phy_divider_reg
    pmc_word_t byp_ff, nxt_byp;   // bypass divider register
    pmc_word_t dat_ff, nxt_dat;   // read data
    logic ack_ff, nxt_ack;        // bus acknowledge
    logic go_wr;                  // go_set_cmd written this cycle
    pmc_go_e go_ff, nxt_go;       // divider transition sequencer
    logic go_stat_ff, nxt_go_stat; // go_status_flag
    logic load;                   // all dividers adopt new ratios
    logic want_pll;               // source requested by the control word
    logic sel_pll;                // source actually in use
    logic src_tick;               // chosen source edge
    logic [2:0] div_tick;         // per divider source edges
    logic [2:0] div_en;           // per divider enables
    pmc_ratio_t div_ratio [3];     // per divider programmed ratios
    pmc_ratio_t div_rst [3];       // per divider reset ratios
    logic [2:0] div_clk;          // divided clock levels
    logic rst_pin_ff, dis_pin_ff, pwr_pin_ff, ref_pin_ff, byp_act_ff; // pin flops
    logic [4:0] mult_pin_ff;      // multiplier pins

    // power-on, warm and maximum resets all land the pll in power-down
    assign grst = rst_i | por_i | warm_rst_i | max_rst_i;

    // byte-lane merge; used for every writable register except the command register
    function automatic pmc_word_t wmerge(input pmc_word_t old, input pmc_word_t wd,
                                         input logic [3:0] sel, input pmc_word_t msk);
        pmc_word_t lanes;
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
        return (old & ~lanes) | (wd & lanes);
    endfunction

    // one address decode shared by the write and read paths
    function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
        return adr == ofs;
    endfunction

    // ---------------------------------------------------------------- bus
    // a request is acknowledged one cycle after it appears; writes commit then
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_mult = mult_ff;
        nxt_vid = vid_ff;
        nxt_phy = phy_ff;
        nxt_byp = byp_ff;
        nxt_dat = dat_ff;
        nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
        go_wr = 1'b0;
        if (nxt_ack && wb_we_i) begin
            if (hit(wb_adr_i, `PMC_OFS_CTL)) begin
                // reserved ones stay set whatever is written
                nxt_ctl = wmerge(ctl_ff, wb_dat_i, wb_sel_i, `PMC_CTL_WMASK);
            end
            if (hit(wb_adr_i, `PMC_OFS_MULT)) begin
                nxt_mult = wmerge(mult_ff, wb_dat_i, wb_sel_i, 32'h0000_001F);
            end
            if (hit(wb_adr_i, `PMC_OFS_VID)) begin
                nxt_vid = wmerge(vid_ff, wb_dat_i, wb_sel_i, `PMC_DIV_WMASK);
            end
            if (hit(wb_adr_i, `PMC_OFS_PHY)) begin
                nxt_phy = wmerge(phy_ff, wb_dat_i, wb_sel_i, `PMC_DIV_WMASK);
            end
            if (hit(wb_adr_i, `PMC_OFS_BYP)) begin
                nxt_byp = wmerge(byp_ff, wb_dat_i, wb_sel_i, `PMC_DIV_WMASK);
            end
            if (hit(wb_adr_i, `PMC_OFS_CMD)) begin
                go_wr = wb_sel_i[0] && wb_dat_i[`PMC_CMD_GO]; // writing zero does nothing
            end
        end
        if (nxt_ack) begin
            // unmapped addresses and the command register read as zero
            nxt_dat = '0;
            if (hit(wb_adr_i, `PMC_OFS_CTL)) begin
                nxt_dat = ctl_ff;
            end
            if (hit(wb_adr_i, `PMC_OFS_MULT)) begin
                nxt_dat = mult_ff;
            end
            if (hit(wb_adr_i, `PMC_OFS_VID)) begin
                nxt_dat = vid_ff;
            end
            if (hit(wb_adr_i, `PMC_OFS_PHY)) begin
                nxt_dat = phy_ff;
            end
            if (hit(wb_adr_i, `PMC_OFS_BYP)) begin
                nxt_dat = byp_ff;
            end
            if (hit(wb_adr_i, `PMC_OFS_STAT)) begin
                nxt_dat = '0;
                nxt_dat[`PMC_STAT_GO] = go_stat_ff;
                nxt_dat[`PMC_STAT_LOCK] = pll_lock_i;
                nxt_dat[`PMC_STAT_SELPLL] = sel_pll;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (grst) begin
            ctl_ff <= `PMC_CTL_RESET;
            mult_ff <= `PMC_MULT_RESET;
            vid_ff <= `PMC_VID_RESET;
            phy_ff <= `PMC_PHY_RESET;
            byp_ff <= `PMC_BYP_RESET;
            dat_ff <= '0;
            ack_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            mult_ff <= nxt_mult;
            vid_ff <= nxt_vid;
            phy_ff <= nxt_phy;
            byp_ff <= nxt_byp;
            dat_ff <= nxt_dat;
            ack_ff <= nxt_ack;
        end
    end

    // ---------------------------------------------------------------- go sequencer
    // ratios are taken together on one source edge, then one period runs before
    // status drops, so software never sees done while an edge is still misaligned
    always_comb begin
        nxt_go = go_ff;
        nxt_go_stat = go_stat_ff;
        load = 1'b0;
        unique case (go_ff)
            PMC_GO_IDLE: begin
                nxt_go_stat = 1'b0;
            end
            PMC_GO_ALIGN: begin
                if (src_tick) begin
                    load = 1'b1;
                    nxt_go = PMC_GO_SETTLE;
                end
            end
            PMC_GO_SETTLE: begin
                if (src_tick) begin
                    nxt_go = PMC_GO_IDLE;
                    nxt_go_stat = 1'b0;
                end
            end
            default: begin
                nxt_go = PMC_GO_IDLE;
            end
        endcase
        if (go_wr) begin
            // a new go wins over a completion in the same cycle
            nxt_go = PMC_GO_ALIGN;
            nxt_go_stat = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (grst) begin
            go_ff <= PMC_GO_IDLE;
            go_stat_ff <= 1'b0;
        end else begin
            go_ff <= nxt_go;
            go_stat_ff <= nxt_go_stat;
        end
    end

    // ---------------------------------------------------------------- source select
    // enable source set keeps bypass; mode enable only counts once it is clear
    assign want_pll = !ctl_ff[`PMC_CTL_ENSRC] && ctl_ff[`PMC_CTL_EN];

    pmc_srcsel u_srcsel (
        .clk_i(clk_i),
        .rst_i(grst),
        .ref_tick_i(ref_tick_i),
        .pll_tick_i(pll_tick_i),
        .want_pll_i(want_pll),
        .pll_ok_i(ctl_ff[`PMC_CTL_RST] && !ctl_ff[`PMC_CTL_DIS] && !ctl_ff[`PMC_CTL_PWRDN]),
        .sel_pll_o(sel_pll),
        .src_tick_o(src_tick)
    );

    // ---------------------------------------------------------------- dividers
    // index 0 video, 1 phy from the selected source; 2 bypass from the reference
    assign div_tick = {ref_tick_i, src_tick, src_tick};
    assign div_en = {byp_ff[`PMC_DIV_EN], phy_ff[`PMC_DIV_EN], vid_ff[`PMC_DIV_EN]};
    assign div_ratio[0] = vid_ff[4:0];
    assign div_ratio[1] = phy_ff[4:0];
    assign div_ratio[2] = byp_ff[4:0];
    assign div_rst[0] = pmc_ratio_t'(`PMC_VID_RESET);
    assign div_rst[1] = pmc_ratio_t'(`PMC_PHY_RESET);
    assign div_rst[2] = pmc_ratio_t'(`PMC_BYP_RESET);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            pmc_clkdiv u_div (
                .clk_i(clk_i),
                .rst_i(grst),
                .tick_i(div_tick[gi]),
                .load_i(load),
                .en_i(div_en[gi]),
                .ratio_i(div_ratio[gi]),
                .reset_ratio_i(div_rst[gi]),
                .clk_o(div_clk[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------- pins
    // pin levels are registered so every output leaves a flop
    always_ff @(posedge clk_i) begin
        if (grst) begin
            rst_pin_ff <= 1'b1;
            dis_pin_ff <= 1'b1;
            pwr_pin_ff <= 1'b1;
            ref_pin_ff <= 1'b0;
            byp_act_ff <= 1'b1;
            mult_pin_ff <= 5'(`PMC_MULT_RESET);
        end else begin
            rst_pin_ff <= !ctl_ff[`PMC_CTL_RST];
            dis_pin_ff <= ctl_ff[`PMC_CTL_DIS];
            pwr_pin_ff <= ctl_ff[`PMC_CTL_PWRDN];
            ref_pin_ff <= ctl_ff[`PMC_CTL_REFSEL];
            byp_act_ff <= !sel_pll;
            mult_pin_ff <= mult_ff[4:0];
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign pll_reset_o = rst_pin_ff;
    assign pll_disable_o = dis_pin_ff;
    assign pll_power_down_o = pwr_pin_ff;
    assign multiplier_setting_o = mult_pin_ff;
    assign ref_source_select_o = ref_pin_ff;
    assign video_clock_out_o = div_clk[0];
    assign phy_clock_out_o = div_clk[1];
    assign bypass_divided_clock_o = div_clk[2];
    assign bypass_active_o = byp_act_ff;

    // ---------------------------------------------------------------- checks
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (grst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    pwrdn_reset_a: assert property (@(posedge clk_i)
        (por_i || warm_rst_i || max_rst_i) |=> ctl_ff[`PMC_CTL_PWRDN] ##1 pll_power_down_o)
        else $error("global reset left pll powered");

    reset_pol_a: assert property (@(posedge clk_i) disable iff (grst)
        $past(!grst) |-> (pll_reset_o == !$past(ctl_ff[`PMC_CTL_RST])))
        else $error("pll reset pin polarity wrong");

    disable_pol_a: assert property (@(posedge clk_i) disable iff (grst)
        $past(!grst) |-> (pll_disable_o == $past(ctl_ff[`PMC_CTL_DIS])))
        else $error("pll disable pin polarity wrong");

    ensrc_block_a: assert property (@(posedge clk_i) disable iff (grst)
        (ctl_ff[`PMC_CTL_ENSRC] && !sel_pll) |=> !sel_pll)
        else $error("mode enable acted while enable source set");

    go_set_a: assert property (@(posedge clk_i) disable iff (grst)
        go_wr |=> go_stat_ff ##0 (go_ff == PMC_GO_ALIGN))
        else $error("go status not raised by go write");

    go_done_a: assert property (@(posedge clk_i) disable iff (grst)
        (go_ff == PMC_GO_SETTLE && src_tick && !go_wr) |=> !go_stat_ff)
        else $error("go status stuck after aligned adoption");

    go_hold_a: assert property (@(posedge clk_i) disable iff (grst)
        (go_stat_ff && !load) |=> (go_stat_ff || $past(go_ff) == PMC_GO_SETTLE))
        else $error("go status dropped before dividers loaded");

    pll_select_a: assert property (@(posedge clk_i) disable iff (grst)
        (want_pll && ref_tick_i) ##1 (want_pll && !ref_tick_i) [*3]
        ##1 (want_pll && ref_tick_i) |=> sel_pll)
        else $error("mode enable did not select pll");
endmodule

// file: dv/tb.sv
// testbench for the memory pll clock controller: wishbone access, bypass switch, go sequence
// assumes pmc_ctrl alone, with reference and pll edges made here as one-cycle ticks
`timescale 1ns/1ps
`include "pmc_params.svh"
module tb;
    import pmc_pkg::*;
    localparam pmc_word_t ONE = 32'h0000_0001;
    localparam pmc_word_t ZERO = 32'h0000_0000;
    logic clk_i = 0, rst_i = 1, por_i = 0, warm_rst_i = 0, max_rst_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hF;
    pmc_word_t wb_dat_i = '0, wb_dat_o, q;
    logic wb_ack_o, ref_tick_i = 0, pll_tick_i = 0, pll_lock_i = 0, pll_run = 0;
    logic pll_reset_o, pll_disable_o, pll_power_down_o, ref_source_select_o;
    logic [4:0] multiplier_setting_o;
    logic video_clock_out_o, phy_clock_out_o, bypass_divided_clock_o, bypass_active_o;
    logic [1:0] tcnt = 0, msel = 0;
    logic mon;
    int miscompares = 0, compares = 0, cyc_cnt = 0, p, i;
    pmc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .warm_rst_i(warm_rst_i),
        .max_rst_i(max_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ref_tick_i(ref_tick_i), .pll_tick_i(pll_tick_i),
        .pll_lock_i(pll_lock_i), .pll_reset_o(pll_reset_o), .pll_disable_o(pll_disable_o),
        .pll_power_down_o(pll_power_down_o), .multiplier_setting_o(multiplier_setting_o),
        .ref_source_select_o(ref_source_select_o), .video_clock_out_o(video_clock_out_o),
        .phy_clock_out_o(phy_clock_out_o), .bypass_divided_clock_o(bypass_divided_clock_o),
        .bypass_active_o(bypass_active_o));
    // clock source for the whole bench
    initial forever #5 clk_i = ~clk_i;
    // reference tick every 4 cycles, pll tick every 2 while running
    always @(posedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        ref_tick_i <= (tcnt == 2'h3);
        pll_tick_i <= pll_run & tcnt[0];
    end
    // watched clock level for period measurement
    assign mon = (msel == 2'h0) ? phy_clock_out_o :
                 (msel == 2'h1) ? video_clock_out_o : bypass_divided_clock_o;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string name, input pmc_word_t seen, input pmc_word_t exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] a, input pmc_word_t d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i <= 0;
        if (n >= 100) miscompares++;
        // let registered pins settle before the caller looks at them
        @(posedge clk_i);
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input pmc_word_t exp);
        wb(1'b0, a, ZERO);
        check(name, q, exp);
    endtask
    // cycles between two rising edges of the selected clock
    task automatic period(input logic [1:0] s, output int pr);
        int n, r;
        logic prev;
        msel = s;
        #1;
        prev = mon;
        n = 0;
        r = 0;
        pr = 0;
        while (r < 2 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
            if (r > 0) pr++;
            if (mon === 1'b1 && prev === 1'b0) r++;
            prev = mon;
        end
    endtask
    // reference ticks seen until the bypass flag reaches lvl
    task automatic waitbyp(input logic lvl);
        int n, t;
        n = 0;
        t = 0;
        while (bypass_active_o !== lvl && t < 200) begin
            @(posedge clk_i);
            #1;
            t++;
            if (ref_tick_i) n++;
        end
        check("switch_ticks", (n <= 4 && t < 200) ? ONE : ZERO, ONE);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rdchk("ctl_rst", `PMC_OFS_CTL, `PMC_CTL_RESET);
        rdchk("mult_rst", `PMC_OFS_MULT, `PMC_MULT_RESET);
        rdchk("vid_rst", `PMC_OFS_VID, `PMC_VID_RESET);
        rdchk("phy_rst", `PMC_OFS_PHY, `PMC_PHY_RESET);
        rdchk("byp_rst", `PMC_OFS_BYP, `PMC_BYP_RESET);
        rdchk("stat_rst", `PMC_OFS_STAT, ZERO);
        rdchk("unmapped", 12'h104, ZERO);
        check("pwrdn_rst", {31'h0, pll_power_down_o}, ONE);
        // power-up path, bypass kept throughout
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0112);
        rdchk("ctl_bypass", `PMC_OFS_CTL, 32'h0000_01D2);
        check("refsel", {31'h0, ref_source_select_o}, ONE);
        check("dis_on", {31'h0, pll_disable_o}, ONE);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0110);
        check("pwrdn_off", {31'h0, pll_power_down_o}, ZERO);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0100);
        check("dis_off", {31'h0, pll_disable_o}, ZERO);
        check("rst_on", {31'h0, pll_reset_o}, ONE);
        wb(1'b1, `PMC_OFS_MULT, 32'h0000_0015);
        check("mult", {27'h0, multiplier_setting_o}, 32'h0000_0015);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0108);
        check("rst_off", {31'h0, pll_reset_o}, ZERO);
        pll_lock_i <= 1;
        pll_run <= 1;
        rdchk("stat_lock", `PMC_OFS_STAT, 32'h0000_0002);
        // pll toggles yet dividers still follow the reference
        period(2'h0, p);
        check("phy_byp", p, 32'h0000_0008);
        period(2'h1, p);
        check("vid_byp", p, 32'h0000_0028);
        period(2'h2, p);
        check("bp_byp", p, 32'h0000_0008);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0109);
        waitbyp(1'b0);
        rdchk("stat_pll", `PMC_OFS_STAT, 32'h0000_0006);
        // go with the pll stalled so the pending state is visible
        rdchk("go_idle", `PMC_OFS_STAT, 32'h0000_0006);
        wb(1'b1, `PMC_OFS_PHY, 32'h0000_8003);
        wb(1'b1, `PMC_OFS_VID, 32'h0000_8001);
        pll_run <= 0;
        wb(1'b1, `PMC_OFS_CMD, ONE);
        rdchk("go_pend", `PMC_OFS_STAT, 32'h0000_0007);
        rdchk("cmd_rd", `PMC_OFS_CMD, ZERO);
        pll_run <= 1;
        i = 0;
        do begin
            wb(1'b0, `PMC_OFS_STAT, ZERO);
            i++;
        end while (q[`PMC_STAT_GO] !== 1'b0 && i < 50);
        check("go_done", q, 32'h0000_0006);
        period(2'h0, p);
        check("phy_new", p, 32'h0000_0008);
        period(2'h1, p);
        check("vid_new", p, 32'h0000_0004);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0108);
        waitbyp(1'b1);
        period(2'h0, p);
        check("phy_ref", p, 32'h0000_0010);
        // short multiplier change: still powered, stabilization already met
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0100);
        wb(1'b1, `PMC_OFS_MULT, 32'h0000_0012);
        check("mult_short", {27'h0, multiplier_setting_o}, 32'h0000_0012);
        wb(1'b1, `PMC_OFS_CTL, 32'h0000_0108);
        // one byte lane only: the source select bit clears, the rest stays
        wb_sel_i <= 4'h2;
        wb(1'b1, `PMC_OFS_CTL, ZERO);
        wb_sel_i <= 4'hF;
        rdchk("ctl_lane", `PMC_OFS_CTL, 32'h0000_00C8);
        // each global reset powers the pll down again
        for (i = 0; i < 3; i++) begin
            @(posedge clk_i);
            por_i <= (i == 0);
            warm_rst_i <= (i == 1);
            max_rst_i <= (i == 2);
            @(posedge clk_i);
            por_i <= 0;
            warm_rst_i <= 0;
            max_rst_i <= 0;
            rdchk("ctl_grst", `PMC_OFS_CTL, `PMC_CTL_RESET);
            check("pwrdn_grst", {31'h0, pll_power_down_o}, ONE);
            wb(1'b1, `PMC_OFS_CTL, 32'h0000_0110);
        end
        give_verdict();
    end
endmodule
